// ### caac_alu.sv
// combinational arithmetic unit with status flags
`include "caac_consts.svh"
`default_nettype none
module caac_alu import caac_pkg::*; (
    input wire caac_op_type op,
    input wire logic [7:0] acc,
    input wire logic [7:0] src,
    input wire logic [7:0] b_val,
    input wire logic carry_in,
    input wire logic aux_in,
    output logic [7:0] result,
    output logic [7:0] result_b,
    output logic carry_out,
    output logic aux_out,
    output logic ov_out
);
    logic cin;
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [8:0] diff;
    logic [4:0] low_diff;
    logic [15:0] prod;
    logic [8:0] adj;
    logic [8:0] adj2;
    logic da_hi;

    always_comb begin
        cin = (op == op_add) ? 1'b0 : carry_in;
        sum = 9'(acc) + 9'(src) + 9'(cin);
        low_sum = 5'(acc[3:0]) + 5'(src[3:0]) + 5'(cin);
        diff = 9'(acc) - 9'(src) - 9'(carry_in);
        low_diff = 5'(acc[3:0]) - 5'(src[3:0]) - 5'(carry_in);
        prod = 16'(acc) * 16'(b_val);
        adj = 9'(acc);
        if (acc[3:0] > `CAAC_NIBBLE_MAX || aux_in) begin
            adj = 9'(acc) + 9'(`CAAC_DA_LOW);
        end
        da_hi = adj[8] || carry_in || (adj[7:4] > `CAAC_NIBBLE_MAX);
        adj2 = 9'(adj[7:0]) + 9'(`CAAC_DA_HIGH);
        result = acc;
        result_b = b_val;
        carry_out = carry_in;
        aux_out = aux_in;
        ov_out = 1'b0;
        case (op)
            op_add, sum_with_carry_op: begin // RULE10 RULE15
                result = sum[7:0];
                carry_out = sum[8];
                aux_out = low_sum[4];
                ov_out = (acc[7] == src[7]) && (sum[7] != acc[7]);
            end
            subtract_with_borrow_op: begin // RULE11 RULE15
                result = diff[7:0];
                carry_out = diff[8];
                aux_out = low_diff[4];
                ov_out = (acc[7] != src[7]) && (diff[7] != acc[7]);
            end
            plus_one_op: result = src + `CAAC_ONE;
            minus_one_op: result = src - `CAAC_ONE;
            product_op: begin // RULE13
                result = prod[7:0];
                result_b = prod[15:8];
                carry_out = 1'b0;
                ov_out = |prod[15:8];
            end
            op_divide: begin // RULE14
                carry_out = 1'b0;
                if (b_val == `CAAC_ZERO) begin
                    ov_out = 1'b1;
                end else begin
                    result = acc / b_val;
                    result_b = acc % b_val;
                end
            end
            decimal_adjust_op: begin // RULE14
                result = da_hi ? adj2[7:0] : adj[7:0];
                carry_out = da_hi;
            end
            default: begin
                result = acc;
            end
        endcase
    end
endmodule
`default_nettype wire

// ### caac_consts.svh
// named constants for the arithmetic and addressing core
`ifndef CAAC_CONSTS_SVH
`define CAAC_CONSTS_SVH

// cycle counts, counted from the first busy cycle
`define CAAC_CYC_FIRST 3'h1
`define CAAC_CYC_SECOND 3'h2
`define CAAC_CYC_ARITH_BANK 3'h1
`define CAAC_CYC_ARITH_MEM 3'h2
`define CAAC_CYC_STEP_ACC 3'h1
`define CAAC_CYC_STEP_BANK 3'h2
`define CAAC_CYC_STEP_MEM 3'h3
`define CAAC_CYC_POINTER_INC 3'h1
`define CAAC_CYC_PRODUCT 3'h2
`define CAAC_CYC_DIV 3'h6
`define CAAC_CYC_DA 3'h3
`define CAAC_CYC_CODE 3'h5
`define CAAC_CYC_EXT 3'h3
`define CAAC_CYC_BIT 3'h2
`define CAAC_CYC_LOAD_POINTER 3'h3

// instruction lengths in bytes
`define CAAC_LEN_ONE 2'h1
`define CAAC_LEN_TWO 2'h2
`define CAAC_LEN_THREE 2'h3

// address forming
`define CAAC_BANK_PAD 3'h0
`define CAAC_PTR_PAD 2'h0
`define CAAC_BIT_RAM_HI 4'h2
`define CAAC_BIT_REG_LOW 3'h0
`define CAAC_SPACE_CODE 1'h0
`define CAAC_SPACE_EXT 1'h1

// arithmetic constants
`define CAAC_ONE 8'h01
`define CAAC_ZERO 8'h00
`define CAAC_NIBBLE_MAX 4'h9
`define CAAC_DA_LOW 8'h06
`define CAAC_DA_HIGH 8'h60

// reset values
`define CAAC_BYTE_RST 8'h00
`define CAAC_WORD_RST 16'h0000

`endif

// ### caac_core.sv
// arithmetic execution and operand addressing core
`include "caac_consts.svh"
`default_nettype none
// How it works
// (RULE1) a direct operand address is the 8-bit byte from the instruction and goes only to the internal RAM port.
// (RULE2) indirect operands use pointer register 0 or 1 as an 8-bit address, the data pointer as a 16-bit one.
// (RULE3) a bank register is one of eight in the selected bank, picked by the opcode's low bits alone.
// (RULE4) implied-register forms act on the accumulator and read no operand from memory.
// (RULE5) an immediate operand is the instruction byte itself and is never used as an address.
// (RULE6) indexed reads go only to program memory, at data pointer plus accumulator.
// (RULE7) a bit operand is one bit of a 256-bit space, taken from RAM below 128 and register bytes above.
// (RULE8) arithmetic accepts direct, indirect, bank register, immediate and implied forms.
// (RULE9) add takes 1 byte/1 cycle from a bank register, 2/2 direct, 1/2 indirect, 2/2 immediate.
// (RULE10) add with carry adds the operand and carry, with the same lengths and cycles as add.
// (RULE11) subtract with borrow takes operand and borrow off the accumulator, timed like add.
// (RULE12) increment/decrement take 1/1 accumulator, 1/2 bank, 2/3 direct, 1/3 indirect; data pointer 1/1.
// (RULE13) multiply of accumulator by the auxiliary register is 1 byte and 2 cycles.
// (RULE14) divide is 1 byte and 6 cycles; decimal adjust is 1 byte and 3 cycles.
// (RULE15) carry, auxiliary carry and overflow follow usual 8-bit accumulator machine rules.
module caac_core import caac_pkg::*; (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic start,
    input wire caac_op_type op,
    input wire caac_mode_type mode,
    input wire logic [2:0] reg_sel,
    input wire logic [7:0] operand_byte,
    input wire logic [7:0] operand_high,
    input wire logic [1:0] bank_sel,
    output logic ready,
    output logic busy,
    output logic done,
    output logic [1:0] instr_len,
    output logic [7:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    output logic [15:0] wide_addr,
    output logic wide_rd,
    output logic wide_space,
    input wire logic [7:0] wide_rdata,
    output logic [7:0] acc,
    output logic [7:0] b_reg,
    output logic [15:0] data_pointer_16,
    output logic carry,
    output logic aux_carry,
    output logic overflow
);
    caac_state_type state;
    caac_op_type op_q;
    caac_mode_type mode_q;
    logic [2:0] cyc;
    logic [2:0] total_q;
    logic [7:0] imm_q;
    logic [7:0] imm_hi_q;
    logic [7:0] operand_q;
    logic accept;
    logic last;
    logic opnd_now;
    logic step_op;
    logic wide_op;
    logic uses_mem;
    logic [7:0] live;
    logic [7:0] src;
    logic [7:0] alu_res;
    logic [7:0] alu_res_b;
    logic alu_c;
    logic alu_ac;
    logic alu_ov;

    function automatic logic [2:0] cycles_of(input caac_op_type o, input caac_mode_type m);
        logic [2:0] n;
        n = `CAAC_CYC_ARITH_MEM;
        unique case (o)
            plus_one_op, minus_one_op: n = (m == mode_implied) ? `CAAC_CYC_STEP_ACC : // RULE12
                (m == mode_bank) ? `CAAC_CYC_STEP_BANK : `CAAC_CYC_STEP_MEM;
            op_inc_pointer: n = `CAAC_CYC_POINTER_INC; // RULE12
            product_op: n = `CAAC_CYC_PRODUCT; // RULE13
            op_divide: n = `CAAC_CYC_DIV; // RULE14
            decimal_adjust_op: n = `CAAC_CYC_DA; // RULE14
            op_read_code: n = `CAAC_CYC_CODE;
            op_read_ext: n = `CAAC_CYC_EXT;
            op_bit_to_carry: n = `CAAC_CYC_BIT;
            op_load_pointer: n = `CAAC_CYC_LOAD_POINTER;
            op_add, sum_with_carry_op, subtract_with_borrow_op, op_move_b: n = // RULE9 RULE10 RULE11
                (m == mode_bank || m == mode_implied) ? `CAAC_CYC_ARITH_BANK : `CAAC_CYC_ARITH_MEM;
        endcase
        return n;
    endfunction

    function automatic logic [1:0] length_of(input caac_op_type o, input caac_mode_type m);
        logic [1:0] n;
        n = `CAAC_LEN_ONE;
        if (o == op_load_pointer) begin
            n = `CAAC_LEN_THREE;
        end else if (o == op_bit_to_carry || m == mode_direct || m == mode_immediate) begin // RULE9 RULE12
            n = `CAAC_LEN_TWO;
        end
        return n;
    endfunction

    // sequencing and handshake
    assign accept = start && (state == st_idle);
    assign ready = (state == st_idle);
    assign busy = (state == st_run);
    assign last = busy && (cyc == total_q);
    assign step_op = (op_q == plus_one_op) || (op_q == minus_one_op);
    assign wide_op = (op_q == op_read_code) || (op_q == op_read_ext);
    assign uses_mem = (op_q == op_bit_to_carry) || // RULE8
        ((op_q == op_add || op_q == sum_with_carry_op || op_q == subtract_with_borrow_op ||
          op_q == op_move_b || step_op) &&
         (mode_q == mode_bank || mode_q == mode_direct || mode_q == mode_indirect));
    assign opnd_now = busy && (cyc == ((mode_q == mode_indirect) ? `CAAC_CYC_SECOND : `CAAC_CYC_FIRST));
    assign mem_rd = busy && uses_mem && (cyc == `CAAC_CYC_FIRST || opnd_now); // RULE2
    assign mem_wr = last && step_op && (mode_q != mode_implied); // RULE12
    assign wide_rd = busy && wide_op && (cyc == `CAAC_CYC_FIRST);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= st_idle;
            cyc <= `CAAC_CYC_FIRST;
            total_q <= `CAAC_CYC_FIRST;
        end else begin
            unique case (state)
                st_idle: begin
                    if (start) begin
                        state <= st_run;
                        cyc <= `CAAC_CYC_FIRST;
                        total_q <= cycles_of(op, mode);
                    end
                end
                st_run: begin
                    if (cyc == total_q) begin
                        state <= st_idle;
                    end else begin
                        cyc <= cyc + `CAAC_CYC_FIRST;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            done <= 1'b0;
        end else begin
            done <= last;
        end
    end

    // instruction fields caught when a request is taken
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            op_q <= op_add;
            mode_q <= mode_implied;
            imm_q <= `CAAC_BYTE_RST;
            imm_hi_q <= `CAAC_BYTE_RST;
            instr_len <= `CAAC_LEN_ONE;
        end else if (accept) begin
            op_q <= op;
            mode_q <= mode;
            imm_q <= operand_byte; // RULE5
            imm_hi_q <= operand_high;
            instr_len <= length_of(op, mode);
        end
    end

    // operand address forming
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mem_addr <= `CAAC_BYTE_RST;
        end else if (accept) begin
            if (op == op_bit_to_carry) begin
                mem_addr <= operand_byte[7] ? {operand_byte[7:3], `CAAC_BIT_REG_LOW} : // RULE7
                    {`CAAC_BIT_RAM_HI, operand_byte[6:3]};
            end else if (mode == mode_direct) begin
                mem_addr <= operand_byte; // RULE1
            end else if (mode == mode_indirect) begin
                mem_addr <= {`CAAC_BANK_PAD, bank_sel, `CAAC_PTR_PAD, reg_sel[0]}; // RULE2
            end else begin
                mem_addr <= {`CAAC_BANK_PAD, bank_sel, reg_sel}; // RULE3
            end
        end else if (busy && mode_q == mode_indirect && cyc == `CAAC_CYC_FIRST) begin
            mem_addr <= mem_rdata; // RULE2
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wide_addr <= `CAAC_WORD_RST;
            wide_space <= `CAAC_SPACE_CODE;
        end else if (accept) begin
            wide_addr <= (op == op_read_code) ? data_pointer_16 + 16'(acc) : data_pointer_16; // RULE6 RULE2
            wide_space <= (op == op_read_code) ? `CAAC_SPACE_CODE : `CAAC_SPACE_EXT; // RULE6
        end
    end

    // operand selection
    always_comb begin
        if (wide_op) begin
            live = wide_rdata;
        end else if (mode_q == mode_implied) begin
            live = acc; // RULE4
        end else if (mode_q == mode_immediate) begin
            live = imm_q; // RULE5
        end else begin
            live = mem_rdata;
        end
        src = opnd_now ? live : operand_q;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            operand_q <= `CAAC_BYTE_RST;
            mem_wdata <= `CAAC_BYTE_RST;
        end else if (opnd_now) begin
            operand_q <= live;
            mem_wdata <= alu_res; // RULE12
        end
    end

    caac_alu u_alu (
        .op(op_q),
        .acc(acc),
        .src(src),
        .b_val(b_reg),
        .carry_in(carry),
        .aux_in(aux_carry),
        .result(alu_res),
        .result_b(alu_res_b),
        .carry_out(alu_c),
        .aux_out(alu_ac),
        .ov_out(alu_ov)
    );

    // architectural state committed in the last busy cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            acc <= `CAAC_BYTE_RST;
            b_reg <= `CAAC_BYTE_RST;
            data_pointer_16 <= `CAAC_WORD_RST;
            carry <= 1'b0;
            aux_carry <= 1'b0;
            overflow <= 1'b0;
        end else if (last) begin
            unique case (op_q)
                op_add, sum_with_carry_op, subtract_with_borrow_op: begin // RULE9 RULE10 RULE11 RULE15
                    acc <= alu_res;
                    carry <= alu_c;
                    aux_carry <= alu_ac;
                    overflow <= alu_ov;
                end
                plus_one_op, minus_one_op: begin
                    if (mode_q == mode_implied) begin
                        acc <= alu_res; // RULE4
                    end
                end
                op_inc_pointer: data_pointer_16 <= data_pointer_16 + 16'(`CAAC_ONE); // RULE12
                product_op, op_divide: begin // RULE13 RULE14 RULE15
                    acc <= alu_res;
                    b_reg <= alu_res_b;
                    carry <= alu_c;
                    overflow <= alu_ov;
                end
                decimal_adjust_op: begin // RULE14
                    acc <= alu_res;
                    carry <= alu_c;
                end
                op_read_code, op_read_ext: acc <= src;
                op_bit_to_carry: carry <= src[imm_q[2:0]]; // RULE7
                op_move_b: b_reg <= src;
                op_load_pointer: data_pointer_16 <= {imm_hi_q, imm_q};
            endcase
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_take(caac_op_type o);
        start && ready && op == o;
    endsequence

    a_add_bank_time: assert property (s_take(op_add) ##0 mode == mode_bank |=> busy ##1 done && !busy) // RULE9
        else $error("bank add not one cycle");
    a_subtract_direct_len: assert property (s_take(subtract_with_borrow_op) ##0 mode == mode_direct // RULE11
        |=> instr_len == `CAAC_LEN_TWO && busy[*2] ##1 done) else $error("direct subtract timing wrong");
    a_product_time: assert property (s_take(product_op) |=> busy[*2] ##1 done && !busy) // RULE13
        else $error("multiply not two cycles");
    a_div_time: assert property (s_take(op_divide) |=> busy[*6] ##1 done && !busy) // RULE14
        else $error("divide not six cycles");
    a_da_time: assert property (s_take(decimal_adjust_op) |=> busy[*3] ##1 done) // RULE14
        else $error("decimal adjust not three cycles");
    a_step_direct_write: assert property (s_take(plus_one_op) ##0 mode == mode_direct // RULE12
        |=> !mem_wr[*2] ##1 mem_wr && mem_addr == $past(operand_byte, 3)) else $error("direct increment write wrong");
    a_indirect_pointer: assert property (start && ready && op == op_add && mode == mode_indirect // RULE2
        |=> mem_rd && mem_addr == {`CAAC_BANK_PAD, $past(bank_sel), `CAAC_PTR_PAD, $past(reg_sel[0])}
        ##1 mem_rd && mem_addr == $past(mem_rdata)) else $error("indirect pointer address wrong");
    a_bank_select: assert property (start && ready && op == sum_with_carry_op && mode == mode_bank // RULE3
        |=> mem_rd && mem_addr == {`CAAC_BANK_PAD, $past(bank_sel), $past(reg_sel)}) else $error("bank address wrong");
    a_immediate_no_read: assert property (s_take(op_add) ##0 mode == mode_immediate |=> !mem_rd[*2]) // RULE5
        else $error("immediate add read memory");
    a_index_code_addr: assert property (s_take(op_read_code) // RULE6
        |=> wide_rd && wide_space == `CAAC_SPACE_CODE && wide_addr == $past(data_pointer_16) + 16'($past(acc)))
        else $error("indexed address wrong");
    a_carry_add_used: assert property (last && op_q == sum_with_carry_op // RULE10 RULE15
        |=> acc == 8'($past(acc) + $past(src) + 8'($past(carry)))) else $error("carry not added");
endmodule
`default_nettype wire

// ### caac_mem_model.sv
// model of internal ram, special function registers and program memory
`default_nettype none
module caac_mem_model (
    input wire logic clock,
    input wire logic [7:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    input wire logic [15:0] wide_addr,
    input wire logic wide_rd,
    input wire logic wide_space,
    output logic [7:0] wide_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ram [256];
    logic [7:0] last;
    initial begin
        foreach (ram[i]) ram[i] = 8'h00;
        last = 8'h00;
    end
    // one byte space for ram and special function registers, idle lines toggle each cycle
    always_comb begin
        mem_rdata = mem_rd ? ram[mem_addr] : ~last;
    end
    // program memory at space 0, external data at space 1
    always_comb begin
        wide_rdata = wide_rd ? (wide_addr[7:0] ^ wide_addr[15:8] ^ (wide_space ? 8'hC3 : 8'h5A)) : ~last;
    end
    always @(posedge clock) begin
        last <= mem_rdata;
        if (mem_wr) begin
            ram[mem_addr] <= mem_wdata;
        end
    end
endmodule
`default_nettype wire

// ### caac_pkg.sv
// types of the arithmetic and addressing core
`default_nettype none
package caac_pkg;
    typedef enum logic [3:0] {
        op_add, sum_with_carry_op, subtract_with_borrow_op, plus_one_op, minus_one_op,
        op_inc_pointer, product_op, op_divide, decimal_adjust_op, op_read_code, op_read_ext,
        op_bit_to_carry, op_move_b, op_load_pointer
    } caac_op_type;
    typedef enum logic [2:0] {
        mode_bank, mode_direct, mode_indirect, mode_immediate, mode_implied
    } caac_mode_type;
    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_run = 2'b10
    } caac_state_type;
endpackage
`default_nettype wire

// ### caac_tb.sv
// self-checking testbench of the arithmetic and addressing core
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %0t mismatch %h vs %h", $time, g, e); end end
module testbench import caac_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, sys_rst, start, ready, busy, done, mem_rd, mem_wr, wide_rd, wide_space;
    logic carry, aux_carry, overflow, rd_seen, wide_seen, w_space, ec, eac, eov;
    caac_op_type op;
    caac_mode_type mode;
    logic [2:0] reg_sel;
    logic [1:0] bank_sel, instr_len;
    logic [7:0] operand_byte, operand_high, mem_addr, mem_wdata, mem_rdata, wide_rdata, acc, b_reg, a_addr, ea;
    logic [15:0] wide_addr, data_pointer_16, w_addr;
    int num_errors, compares;
    caac_core dut_u (.clock(clock), .sys_rst(sys_rst), .start(start), .op(op), .mode(mode),
        .reg_sel(reg_sel), .operand_byte(operand_byte), .operand_high(operand_high), .bank_sel(bank_sel),
        .ready(ready), .busy(busy), .done(done), .instr_len(instr_len), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .wide_addr(wide_addr),
        .wide_rd(wide_rd), .wide_space(wide_space), .wide_rdata(wide_rdata), .acc(acc), .b_reg(b_reg),
        .data_pointer_16(data_pointer_16), .carry(carry), .aux_carry(aux_carry), .overflow(overflow));
    caac_mem_model mem_u (.clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .wide_addr(wide_addr), .wide_rd(wide_rd),
        .wide_space(wide_space), .wide_rdata(wide_rdata));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic give_verdict();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // issue one instruction, count busy cycles up to done
    task automatic run(input caac_op_type o, input caac_mode_type m, input logic [2:0] r,
        input logic [7:0] v, input int n, input logic [1:0] len);
        int k;
        int i;
        @(negedge clock);
        op = o;
        mode = m;
        reg_sel = r;
        operand_byte = v;
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        a_addr = mem_addr;
        w_addr = wide_addr;
        w_space = wide_space;
        rd_seen = 1'b0;
        wide_seen = 1'b0;
        k = 0;
        for (i = 0; i < 20 && done !== 1'b1; i++) begin
            k += int'(busy === 1'b1);
            rd_seen |= mem_rd | mem_wr;
            wide_seen |= wide_rd;
            @(negedge clock);
        end
        if (done !== 1'b1) begin
            num_errors++;
            give_verdict();
        end
        `CHK(k, n)
        `CHK(instr_len, len)
    endtask
    // expected accumulator and flags of add, add with carry, subtract with borrow
    task automatic arith(input caac_op_type o, input logic [7:0] s);
        logic [8:0] r;
        logic [4:0] l;
        logic ci;
        ci = (o == op_add) ? 1'b0 : ec;
        if (o == subtract_with_borrow_op) begin
            r = 9'(ea) - 9'(s) - 9'(ci);
            l = 5'(ea[3:0]) - 5'(s[3:0]) - 5'(ci);
            eov = (ea[7] != s[7]) && (r[7] != ea[7]);
        end else begin
            r = 9'(ea) + 9'(s) + 9'(ci);
            l = 5'(ea[3:0]) + 5'(s[3:0]) + 5'(ci);
            eov = (ea[7] == s[7]) && (r[7] != ea[7]);
        end
        ec = r[8];
        eac = l[4];
        ea = r[7:0];
    endtask
    task automatic t_arith();
        caac_op_type ops [3] = '{op_add, sum_with_carry_op, subtract_with_borrow_op};
        caac_mode_type ms [4] = '{mode_bank, mode_direct, mode_indirect, mode_immediate};
        logic [7:0] sv [4] = '{8'hC7, 8'h89, 8'h3F, 8'h9E};
        logic [7:0] av [4] = '{8'h13, 8'h40, 8'h11, 8'h9E};
        int nv [4] = '{1, 2, 2, 2};
        bank_sel = 2'h2;
        mem_u.ram[8'h13] = 8'hC7;
        mem_u.ram[8'h40] = 8'h89;
        mem_u.ram[8'h11] = 8'h55;
        mem_u.ram[8'h55] = 8'h3F;
        foreach (ops[i]) foreach (ms[j]) begin
            run(ops[i], ms[j], 3'h3, av[j], nv[j], 2'((j % 2) + 1));
            arith(ops[i], sv[j]);
            `CHK(acc, ea)
            `CHK({carry, aux_carry, overflow}, {ec, eac, eov})
            if (j < 3) `CHK(a_addr, av[j])
            `CHK(rd_seen, 1'(j < 3))
        end
    endtask
    task automatic t_step();
        caac_mode_type ms [4] = '{mode_implied, mode_bank, mode_direct, mode_indirect};
        int nv [4] = '{1, 2, 3, 3};
        logic [7:0] loc [4] = '{8'h00, 8'h13, 8'h40, 8'h55};
        logic [7:0] o;
        logic [7:0] e;
        foreach (ms[j]) for (int d = 0; d < 2; d++) begin
            o = (j == 0) ? ea : mem_u.ram[loc[j]];
            e = (d == 1) ? o - 8'h01 : o + 8'h01;
            run((d == 1) ? minus_one_op : plus_one_op, ms[j], 3'h3, 8'h40, nv[j], (j == 2) ? 2'h2 : 2'h1);
            `CHK((j == 0) ? acc : mem_u.ram[loc[j]], e)
            `CHK({carry, aux_carry, overflow}, {ec, eac, eov})
            if (j == 0) `CHK(rd_seen, 1'b0)
            if (j == 0) ea = e;
        end
        operand_high = 8'h12;
        run(op_load_pointer, mode_immediate, 3'h0, 8'hFF, 3, 2'h3);
        run(op_inc_pointer, mode_implied, 3'h0, 8'h00, 1, 2'h1);
        `CHK(data_pointer_16, 16'h1300)
    endtask
    task automatic set_ab(input logic [7:0] a, input logic [7:0] b);
        run(op_add, mode_immediate, 3'h0, a - ea, 2, 2'h2);
        arith(op_add, a - ea);
        run(op_move_b, mode_immediate, 3'h0, b, 2, 2'h2);
        `CHK({acc, b_reg}, {a, b})
    endtask
    task automatic t_muldiv();
        set_ab(8'h50, 8'h04);
        run(product_op, mode_implied, 3'h0, 8'h00, 2, 2'h1);
        `CHK({b_reg, acc, carry, overflow}, {16'h0140, 2'b01})
        ea = 8'h40;
        set_ab(8'hC8, 8'h07);
        run(op_divide, mode_implied, 3'h0, 8'h00, 6, 2'h1);
        `CHK({acc, b_reg, carry, overflow}, {16'h1C04, 2'b00})
        ea = 8'h1C;
        set_ab(8'h2A, 8'h00);
        run(op_divide, mode_implied, 3'h0, 8'h00, 6, 2'h1);
        `CHK({acc, b_reg, carry, overflow}, {16'h2A00, 2'b01})
        set_ab(8'h38, 8'h00);
        run(op_add, mode_immediate, 3'h0, 8'h29, 2, 2'h2);
        run(decimal_adjust_op, mode_implied, 3'h0, 8'h00, 3, 2'h1);
        `CHK({acc, carry}, {8'h67, 1'b0})
        ea = 8'h67;
        set_ab(8'h99, 8'h00);
        run(op_add, mode_immediate, 3'h0, 8'h01, 2, 2'h2);
        run(decimal_adjust_op, mode_implied, 3'h0, 8'h00, 3, 2'h1);
        `CHK({acc, carry}, {8'h00, 1'b1})
        ea = 8'h00;
    endtask
    task automatic t_index();
        set_ab(8'h34, 8'h00);
        operand_high = 8'h0A;
        run(op_load_pointer, mode_immediate, 3'h0, 8'hF0, 3, 2'h3);
        run(op_read_code, mode_implied, 3'h0, 8'h00, 5, 2'h1);
        `CHK({w_addr, w_space, rd_seen, wide_seen}, {16'h0B24, 3'b001})
        `CHK(acc, 8'h24 ^ 8'h0B ^ 8'h5A)
        run(op_read_ext, mode_implied, 3'h0, 8'h00, 3, 2'h1);
        `CHK({w_addr, w_space}, {16'h0AF0, 1'b1})
        `CHK(acc, 8'hF0 ^ 8'h0A ^ 8'hC3)
    endtask
    task automatic t_bit();
        mem_u.ram[8'h21] = 8'h20;
        mem_u.ram[8'h80] = 8'hF7;
        run(op_bit_to_carry, mode_direct, 3'h0, 8'h0D, 2, 2'h2);
        `CHK({a_addr, carry}, {8'h21, 1'b1})
        run(op_bit_to_carry, mode_direct, 3'h0, 8'h83, 2, 2'h2);
        `CHK({a_addr, carry}, {8'h80, 1'b0})
    endtask
    initial begin
        sys_rst = 1'b1;
        start = 1'b0;
        op = op_add;
        mode = mode_bank;
        reg_sel = 3'h0;
        operand_byte = 8'h00;
        operand_high = 8'h00;
        bank_sel = 2'h0;
        num_errors = 0;
        compares = 0;
        ea = 8'h00;
        ec = 1'b0;
        eac = 1'b0;
        eov = 1'b0;
        repeat (12) @(negedge clock);
        `CHK({ready, busy, done, acc, b_reg, data_pointer_16, carry}, {3'b100, 33'h0})
        sys_rst = 1'b0;
        t_arith();
        t_step();
        t_muldiv();
        t_index();
        t_bit();
        give_verdict();
    end
endmodule
`default_nettype wire
